/* shared/pc_load_defs.svh */
// register offsets, field positions and reset values of the counter load block
`ifndef PC_LOAD_DEFS_SVH
`define PC_LOAD_DEFS_SVH
`define OFS_COUNTER_LOW_BYTE 12'h002
`define OFS_COUNTER_HIGH_LATCH 12'h00a
`define OFS_FLAGS_CTX 12'hfe4
`define OFS_WORK_CTX 12'hfe5
`define OFS_BANK_CTX 12'hfe6
`define OFS_LATCH_CTX 12'hfe7
`define OFS_PTR0L_CTX 12'hfe8
`define OFS_PTR0H_CTX 12'hfe9
`define OFS_PTR1L_CTX 12'hfea
`define OFS_PTR1H_CTX 12'hfeb
`define OFS_STACK_INDEX 12'hfed
`define OFS_STACK_TOP_LOW 12'hfee
`define OFS_STACK_TOP_HIGH 12'hfef
`define OFS_COUNTER_CTRL 12'hff0
`define OFS_COUNTER_VIEW_LOW 12'hff1
`define OFS_COUNTER_VIEW_HIGH 12'hff2
`define PC_WIDTH 15
`define PC_HIGH_WIDTH 7
`define STACK_INDEX_WIDTH 5
`define STACK_DEPTH 16
`define STACK_INDEX_RESET 5'h1f
`define CTX_FLAGS_WIDTH 3
`define CTX_BANK_WIDTH 5
`define CTRL_ADVANCE_BIT 0
`define CTRL_ADD_BIT 1
`endif

/* shared/pc_load_pkg.sv */
// types shared by the counter load block
package pc_load_pkg;
    typedef logic [14:0] pc_t;
    typedef enum logic [1:0] {LOAD_NONE, LOAD_ADVANCE, LOAD_LOW_WRITE, LOAD_ADD_WORK} load_kind_e;
endpackage

/* hw/return_stack_mem.sv */
// sixteen-entry return stack storage with registered read data
`timescale 1ns/1ps
module return_stack_mem
(
    // clock
    input wire logic clk_sys_i,
    // write side
    input wire logic wr_en_i,
    input wire logic [3:0] wr_addr_i,
    input wire logic [14:0] wr_data_i,
    // read side
    input wire logic [3:0] rd_addr_i,
    output logic [14:0] rd_data_o
);
    logic [14:0] mem [0:15];

    // storage is never reset, contents are unknown until written
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // registered read port
    always_ff @(posedge clk_sys_i)
    begin
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

/* hw/context_copy_reg.sv */
// one context copy register, untouched by any reset
`timescale 1ns/1ps
module context_copy_reg #(
    parameter int WIDTH = 8
)
(
    // clock
    input wire logic clk_sys_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // held value
    output logic [WIDTH-1:0] value_o
);
    // no reset branch: value survives every reset, powers up unknown
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_en_i)
        begin
            value_o <= wr_data_i;
        end
    end
endmodule

/* hw/program_counter_load_logic.sv */
// program counter loading, return stack access and context copy registers
// Notes on behaviour
// - the program counter is fifteen bits wide and addresses instruction words.
// - the low eight counter bits are the counter low byte register, readable and writable.
// - the upper seven counter bits cannot be read or written directly; they load from the high latch or take the carry when the counter advances.
// - every reset clears the whole program counter to zero.
// - any write to the counter low byte also copies the high latch into the upper seven counter bits.
// - such a write changes all fifteen counter bits at once.
// - adding the work register to the counter low byte makes a computed jump.
// - the stack index is five bits wide so overflow and underflow past sixteen levels are seen.
// - the stack top high and low pair shows the entry picked by the stack index, both readable and writable.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "pc_load_defs.svh"
module program_counter_load_logic
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // core side
    input wire logic [7:0] work_reg_i,
    output logic [14:0] pc_o
);
    pc_load_pkg::pc_t pc;
    pc_load_pkg::pc_t next_pc;
    pc_load_pkg::load_kind_e load_kind;
    logic [6:0] counter_high_latch;
    logic [4:0] return_stack_index;
    logic [14:0] stack_top;
    logic [14:0] stack_wr_data;
    logic stack_wr;
    logic [7:0] read_mux;
    logic [7:0] add_sum;
    logic [7:0] ctx_value [0:7];
    logic [7:0] ctx_wr_en;
    logic wr_low;
    logic advance_req;
    logic add_req;

    // decode of the two counter requests and of writes to the low byte
    assign wr_low = reg_wr_i && (reg_addr_i == `OFS_COUNTER_LOW_BYTE);
    assign advance_req = reg_wr_i && (reg_addr_i == `OFS_COUNTER_CTRL) && reg_wdata_i[`CTRL_ADVANCE_BIT];
    assign add_req = reg_wr_i && (reg_addr_i == `OFS_COUNTER_CTRL) && reg_wdata_i[`CTRL_ADD_BIT];
    // low byte add wraps inside eight bits, no carry reaches the upper bits
    assign add_sum = pc[7:0] + work_reg_i;

    // choose how the counter loads this cycle; a low byte write wins over the others
    always_comb
    begin
        if (wr_low)
        begin
            load_kind = pc_load_pkg::LOAD_LOW_WRITE;
        end
        else if (add_req)
        begin
            load_kind = pc_load_pkg::LOAD_ADD_WORK;
        end
        else if (advance_req)
        begin
            load_kind = pc_load_pkg::LOAD_ADVANCE;
        end
        else
        begin
            load_kind = pc_load_pkg::LOAD_NONE;
        end
    end

    // next counter value
    always_comb
    begin
        unique case (load_kind)
            pc_load_pkg::LOAD_LOW_WRITE: next_pc = {counter_high_latch, reg_wdata_i};
            pc_load_pkg::LOAD_ADD_WORK: next_pc = {counter_high_latch, add_sum};
            pc_load_pkg::LOAD_ADVANCE: next_pc = pc + 15'h0001;
            pc_load_pkg::LOAD_NONE: next_pc = pc;
        endcase
    end

    // program counter, cleared by reset
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pc <= 15'h0000;
        end
        else
        begin
            pc <= next_pc;
        end
    end

    // high latch holds the pending upper bits
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            counter_high_latch <= 7'h00;
        end
        else if (reg_wr_i && reg_addr_i == `OFS_COUNTER_HIGH_LATCH)
        begin
            counter_high_latch <= reg_wdata_i[6:0];
        end
    end

    // stack index, five bits so one step past either end is visible
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            return_stack_index <= `STACK_INDEX_RESET;
        end
        else if (reg_wr_i && reg_addr_i == `OFS_STACK_INDEX)
        begin
            return_stack_index <= reg_wdata_i[4:0];
        end
    end

    // top of stack writes merge one half into the selected entry
    always_comb
    begin
        stack_wr = 1'b0;
        stack_wr_data = stack_top;
        if (reg_wr_i && reg_addr_i == `OFS_STACK_TOP_LOW)
        begin
            stack_wr = 1'b1;
            stack_wr_data = {stack_top[14:8], reg_wdata_i};
        end
        else if (reg_wr_i && reg_addr_i == `OFS_STACK_TOP_HIGH)
        begin
            stack_wr = 1'b1;
            stack_wr_data = {reg_wdata_i[6:0], stack_top[7:0]};
        end
    end

    // storage follows the low four index bits, so the read lags an index change by one cycle
    return_stack_mem u_stack
    (
        .clk_sys_i(clk_sys_i),
        .wr_en_i(stack_wr),
        .wr_addr_i(return_stack_index[3:0]),
        .wr_data_i(stack_wr_data),
        .rd_addr_i(return_stack_index[3:0]),
        .rd_data_o(stack_top)
    );

    // eight context copies sit at consecutive offsets
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_ctx
            assign ctx_wr_en[gi] = reg_wr_i && (reg_addr_i == (`OFS_FLAGS_CTX + 12'(gi)));
            context_copy_reg #(.WIDTH(8)) u_ctx
            (
                .clk_sys_i(clk_sys_i),
                .wr_en_i(ctx_wr_en[gi]),
                .wr_data_i(reg_wdata_i),
                .value_o(ctx_value[gi])
            );
        end
    endgenerate

    // read multiplexer; unmapped offsets and unused upper bits read zero
    always_comb
    begin
        read_mux = 8'h00;
        unique case (reg_addr_i)
            `OFS_COUNTER_LOW_BYTE: read_mux = pc[7:0];
            `OFS_COUNTER_HIGH_LATCH: read_mux = {1'b0, counter_high_latch};
            `OFS_FLAGS_CTX: read_mux = {5'h00, ctx_value[0][2:0]};
            `OFS_WORK_CTX: read_mux = ctx_value[1];
            `OFS_BANK_CTX: read_mux = {3'h0, ctx_value[2][4:0]};
            `OFS_LATCH_CTX: read_mux = {1'b0, ctx_value[3][6:0]};
            `OFS_PTR0L_CTX: read_mux = ctx_value[4];
            `OFS_PTR0H_CTX: read_mux = ctx_value[5];
            `OFS_PTR1L_CTX: read_mux = ctx_value[6];
            `OFS_PTR1H_CTX: read_mux = ctx_value[7];
            `OFS_STACK_INDEX: read_mux = {3'h0, return_stack_index};
            `OFS_STACK_TOP_LOW: read_mux = stack_top[7:0];
            `OFS_STACK_TOP_HIGH: read_mux = {1'b0, stack_top[14:8]};
            `OFS_COUNTER_VIEW_LOW: read_mux = pc[7:0];
            default: read_mux = 8'h00; // upper bits have no read path
        endcase
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            reg_rdata_o <= reg_rd_i ? read_mux : 8'h00;
        end
    end

    // counter to the core straight from a flip-flop
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pc_o <= 15'h0000;
        end
        else
        begin
            pc_o <= next_pc;
        end
    end
endmodule

/* sim/pc_load_checker.sv */
// port assertions for the counter load block
`timescale 1ns/1ps
module pc_load_checker
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // core side
    input wire logic [7:0] work_reg_i,
    input wire logic [14:0] pc_o
);
    logic [6:0] latch;
    logic [4:0] index;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // latch and index copies, so loads can be predicted
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            latch <= 7'h00;
            index <= 5'h1f;
        end
        else if (reg_wr_i && reg_addr_i == 12'h00a)
            latch <= reg_wdata_i[6:0];
        else if (reg_wr_i && reg_addr_i == 12'hfed)
            index <= reg_wdata_i[4:0];
    end
    reset_clear_a: assert property ($fell(rst_i) |-> pc_o == 15'h0000 && reg_rdata_o == 8'h00)
        else $error("pc not clear");
    low_write_a: assert property (reg_wr_i && reg_addr_i == 12'h002 |=> pc_o == {$past(latch), $past(reg_wdata_i)})
        else $error("low write load");
    pc_hold_a: assert property (!(reg_wr_i && (reg_addr_i == 12'h002 || reg_addr_i == 12'hff0)) |=> $stable(pc_o))
        else $error("pc moved");
    add_jump_a: assert property (reg_wr_i && reg_addr_i == 12'hff0 && reg_wdata_i[1]
        |=> pc_o == {$past(latch), 8'($past(pc_o[7:0]) + $past(work_reg_i))})
        else $error("add load");
    advance_a: assert property (reg_wr_i && reg_addr_i == 12'hff0 && reg_wdata_i[1:0] == 2'b01
        |=> pc_o == $past(pc_o) + 15'h0001)
        else $error("advance");
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("rdata not idle");
    low_read_a: assert property (reg_rd_i && reg_addr_i == 12'h002 |=> reg_rdata_o == $past(pc_o[7:0]))
        else $error("low read");
    index_read_a: assert property (reg_rd_i && reg_addr_i == 12'hfed |=> reg_rdata_o == {3'h0, $past(index)})
        else $error("index read");
endmodule

/* sim/tb_top.sv */
// self-checking bench for the counter load block
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [7:0] work_reg_i = 8'h00;
    logic [14:0] pc_o;
    int mismatches = 0;
    int comparisons = 0;
    logic [7:0] mask [8] = '{8'h07, 8'hff, 8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
    program_counter_load_logic u_program_counter_load_logic (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .work_reg_i, .pc_o);
    // 200 MHz clock
    always #2.5 clk_sys_i = ~clk_sys_i;
    // compare any result against its expectation
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one write strobe, then let the load land
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    // one read strobe, data stands only in the next cycle
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk({7'h00, reg_rdata_o}, {7'h00, exp});
    endtask
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(12'hfed, 8'h1f);
        wr(12'h00a, 8'h12);
        wr(12'h002, 8'h34);
        #1 chk(pc_o, 15'h1234);
        rd(12'h002, 8'h34);
        rd(12'hff1, 8'h34);
        rd(12'h00a, 8'h12);
        rd(12'hff2, 8'h00);
        wr(12'h00a, 8'hff);
        wr(12'h002, 8'hf0);
        #1 chk(pc_o, 15'h7ff0);
        rd(12'h00a, 8'h7f);
        @(posedge clk_sys_i);
        work_reg_i <= 8'h25;
        wr(12'h00a, 8'h05);
        wr(12'hff0, 8'h02);
        #1 chk(pc_o, 15'h0515);
        wr(12'hff0, 8'h03);
        #1 chk(pc_o, 15'h053a);
        wr(12'h002, 8'hff);
        wr(12'hff0, 8'h01);
        #1 chk(pc_o, 15'h0600);
        // two entries, so a wrong index shows up
        wr(12'hfed, 8'h03);
        wr(12'hfee, 8'hab);
        wr(12'hfef, 8'hd5);
        wr(12'hfed, 8'h04);
        wr(12'hfee, 8'h11);
        wr(12'hfed, 8'h03);
        rd(12'hfee, 8'hab);
        rd(12'hfef, 8'h55);
        for (int i = 0; i < 8; i++)
            wr(12'hfe4 + 12'(i), {3'(i), 5'h1f});
        wr(12'hfec, 8'h5a);
        // reset mid-run must spare the context copies
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1 chk(pc_o, 15'h0000);
        for (int i = 0; i < 8; i++)
            rd(12'hfe4 + 12'(i), {3'(i), 5'h1f} & mask[i]);
        rd(12'hfec, 8'h00);
        rd(12'h00a, 8'h00);
        rd(12'hfed, 8'h1f);
        print_verdict();
    end
    // hang guard, the tests need about a hundred cycles
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        mismatches++;
        print_verdict();
    end
endmodule
bind program_counter_load_logic pc_load_checker u_pc_load_checker (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .work_reg_i, .pc_o);
